/* File: hw/tcc_pkg.sv */
// shared constants of the timer capture/compare core
package tcc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IX_FUNC_SEL  = 8'h80;
	localparam logic [7:0] IX_C7_MASK   = 8'h82;
	localparam logic [7:0] IX_C7_DATA   = 8'h83;
	localparam logic [7:0] IX_COUNT     = 8'h84;
	localparam logic [7:0] IX_SYS_CTRL  = 8'h86;
	localparam logic [7:0] IX_ACT_HI    = 8'h88;
	localparam logic [7:0] IX_ACT_LO    = 8'h89;
	localparam logic [7:0] IX_EDGE_HI   = 8'h8A;
	localparam logic [7:0] IX_EDGE_LO   = 8'h8B;
	localparam logic [7:0] IX_CH_IRQ_EN = 8'h8C;
	localparam logic [7:0] IX_OVF_PRE   = 8'h8D;
	localparam logic [7:0] IX_CH_FLAGS  = 8'h8E;
	localparam logic [7:0] IX_OVF_FLAG  = 8'h8F;
	localparam logic [3:0] IX_CH_BASE_HI = 4'h9;
	localparam logic [7:0] IX_PA_COUNT  = 8'hA2;
	localparam int         ADDR_W       = 10;
	// system control fields
	localparam int B_TIMER_ON   = 7;
	localparam int B_HALT_WAIT  = 6;
	localparam int B_HALT_DEBUG = 5;
	localparam int B_FAST_CLR   = 4;
	// overflow / prescale control fields
	localparam int B_OVF_IRQ_EN = 7;
	localparam int B_CLR_ON_CH7 = 3;
	localparam int B_OVF_FLAG   = 7;
	// prescaler
	localparam int         PRE_W      = 6;
	localparam logic [2:0] PRE_SEL_MAX = 3'h5;
	localparam logic [PRE_W-1:0] PRE_ALL_ONES = 6'h3F;
	// compare actions
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_TOG = 2'h1;
	localparam logic [1:0] ACT_CLR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	// bus answers and reset values
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
endpackage : tcc_pkg

/* File: hw/tcc_tick_if.sv */
// prescaler control and tick signals between core and prescaler
`timescale 1ns/1ns
`default_nettype none
interface tcc_tick_if;
	logic       active;
	logic [2:0] sel;
	logic       tick;
	logic       div64;
	modport ctrl (output active, output sel, input tick, input div64);
	modport pre  (input active, input sel, output tick, output div64);
endinterface : tcc_tick_if
`default_nettype wire

/* File: hw/tcc_prescale.sv */
// prescaler with synchronised selection change and divide-by-64 tick
`timescale 1ns/1ns
`default_nettype none
module tcc_prescale
	import tcc_pkg::*;
(
	input  wire logic clk,
	input  wire logic arst_n,
	tcc_tick_if.pre   tk
);
	logic [PRE_W-1:0] cnt_r;
	logic [2:0]       sel_r;
	logic [PRE_W-1:0] mask_w;
	logic [2:0]       sel_lim_w;

	// reserved codes behave as the largest factor
	assign sel_lim_w = (tk.sel > PRE_SEL_MAX) ? PRE_SEL_MAX : tk.sel;
	assign mask_w    = PRE_W'((7'h01 << sel_r) - 7'h01);
	assign tk.tick   = tk.active && ((cnt_r & mask_w) == '0);
	assign tk.div64  = tk.active && (cnt_r == PRE_ALL_ONES);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= '0;
			sel_r <= '0;
		end else begin
			if (tk.active)
				cnt_r <= cnt_r + 6'h01;
			if (cnt_r == '0)
				sel_r <= sel_lim_w;
		end
	end
endmodule : tcc_prescale
`default_nettype wire

/* File: hw/tcc_edge.sv */
// per-channel capture edge detectors
`timescale 1ns/1ns
`default_nettype none
module tcc_edge
	import tcc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        active,
	input  wire logic [7:0]  pin_s,
	input  wire logic [15:0] edge_cfg,
	output logic      [7:0]  cap
);
	logic [7:0] prev_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			prev_r <= RST_BYTE;
		else
			prev_r <= pin_s;
	end

	for (genvar n = 0; n < 8; n++) begin : g_ch
		assign cap[n] = active &&
			((edge_cfg[2*n] && pin_s[n] && !prev_r[n]) ||
			 (edge_cfg[2*n+1] && !pin_s[n] && prev_r[n]));
	end
endmodule : tcc_edge
`default_nettype wire

/* File: hw/tcc_core.sv */
// timer capture/compare core with AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
module tcc_core
	import tcc_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              ARST_N,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              WVALID,
	output logic                   WREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	output logic                   BVALID,
	input  wire logic              BREADY,
	output logic      [1:0]        BRESP,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	output logic                   RVALID,
	input  wire logic              RREADY,
	output logic      [31:0]       RDATA,
	output logic      [1:0]        RRESP,
	input  wire logic [7:0]        TP_IN,
	input  wire logic [7:0]        PORT_DIR,
	input  wire logic [7:0]        PORT_DATA,
	input  wire logic              WAIT_MODE,
	input  wire logic              DEBUG_MODE,
	input  wire logic              SPECIAL_MODE,
	output logic      [7:0]        TP_OUT,
	output logic      [7:0]        TP_OE,
	output logic      [7:0]        IRQ_CH,
	output logic                   IRQ_OVF,
	output logic                   PA_DIV64,
	output logic                   PA_FLAG_CLR
);
	////////////////////////////////////////////////////////////////////////
	// synchronisers
	logic [10:0] sy1_r, sy2_r;
	logic [7:0]  pin_s;
	logic        wait_s, dbg_s, spec_s;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sy1_r <= '0;
			sy2_r <= '0;
		end else begin
			sy1_r <= {SPECIAL_MODE, DEBUG_MODE, WAIT_MODE, TP_IN};
			sy2_r <= sy1_r;
		end
	end
	assign {spec_s, dbg_s, wait_s, pin_s} = sy2_r;

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]  ios_r, c7m_r, c7d_r, system_control_r, act_hi_r, act_lo_r;
	logic [7:0]  edg_hi_r, edg_lo_r, ien_r, ovp_r, flg_r;
	logic        tof_r;
	logic [15:0] cnt_r;
	logic [15:0] tc_r [8];
	logic [7:0]  oc_r;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic              awf_r, wf_r, awready_r, wready_r, bvalid_r;
	logic              arready_r, rvalid_r;
	logic [1:0]        bresp_r, rresp_r;
	logic [31:0]       rdata_r, wdata_r;
	logic [3:0]        wstrb_r;
	logic [7:0]        wix_r;
	logic              aw_fire, w_fire, ar_fire, wr_do;
	logic              awf_nxt, wf_nxt, bvalid_nxt, rvalid_nxt;
	logic [7:0]        rix;

	assign aw_fire    = AWVALID && awready_r;
	assign w_fire     = WVALID && wready_r;
	assign ar_fire    = ARVALID && arready_r;
	assign wr_do      = awf_r && wf_r && !bvalid_r;
	assign awf_nxt    = (awf_r || aw_fire) && !wr_do;
	assign wf_nxt     = (wf_r || w_fire) && !wr_do;
	assign bvalid_nxt = wr_do || (bvalid_r && !BREADY);
	assign rvalid_nxt = ar_fire || (rvalid_r && !RREADY);
	assign rix        = ARADDR[ADDR_W-1:2];

	function automatic logic mapped(input logic [7:0] ix);
		mapped = (ix >= IX_FUNC_SEL && ix <= IX_OVF_FLAG
			&& ix != 8'h81 && ix != 8'h85 && ix != 8'h87)
			|| (ix[7:4] == IX_CH_BASE_HI && !ix[0])
			|| ix == IX_PA_COUNT;
	endfunction : mapped

	// channel register hits
	logic       w_tc, r_tc;
	logic [2:0] w_ch, r_ch;
	assign w_tc = wr_do && wix_r[7:4] == IX_CH_BASE_HI && !wix_r[0];
	assign r_tc = ar_fire && rix[7:4] == IX_CH_BASE_HI && !rix[0];
	assign w_ch = wix_r[3:1];
	assign r_ch = rix[3:1];

	logic [31:0] rmux;
	always_comb begin
		rmux = '0;
		case (rix)
			IX_FUNC_SEL:  rmux[7:0] = ios_r;
			IX_C7_MASK:   rmux[7:0] = c7m_r;
			IX_C7_DATA:   rmux[7:0] = c7d_r;
			IX_COUNT:     rmux[15:0] = cnt_r;
			IX_SYS_CTRL:  rmux[7:0] = system_control_r;
			IX_ACT_HI:    rmux[7:0] = act_hi_r;
			IX_ACT_LO:    rmux[7:0] = act_lo_r;
			IX_EDGE_HI:   rmux[7:0] = edg_hi_r;
			IX_EDGE_LO:   rmux[7:0] = edg_lo_r;
			IX_CH_IRQ_EN: rmux[7:0] = ien_r;
			IX_OVF_PRE:   rmux[7:0] = ovp_r;
			IX_CH_FLAGS:  rmux[7:0] = flg_r;
			IX_OVF_FLAG:  rmux[B_OVF_FLAG] = tof_r;
			default:      rmux[15:0] = r_tc ? tc_r[r_ch] : RST_WORD;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			awf_r <= 1'b0;
			wf_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			wix_r <= RST_BYTE;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			awf_r <= awf_nxt;
			wf_r <= wf_nxt;
			awready_r <= !awf_nxt && !bvalid_nxt;
			wready_r <= !wf_nxt && !bvalid_nxt;
			bvalid_r <= bvalid_nxt;
			if (aw_fire)
				wix_r <= AWADDR[ADDR_W-1:2];
			if (w_fire) begin
				wdata_r <= WDATA;
				wstrb_r <= WSTRB;
			end
			if (wr_do)
				bresp_r <= mapped(wix_r) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else begin
			arready_r <= !rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_fire) begin
				rdata_r <= rmux;
				rresp_r <= mapped(rix) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// prescaler, edge detectors, compare
	tcc_tick_if tk ();
	logic        active;
	logic [7:0]  cap, match, force_w, oc_nxt;
	logic [15:0] act_w;
	logic        ch7_hit, wrap, fast;

	assign active = system_control_r[B_TIMER_ON]
		&& !(wait_s && system_control_r[B_HALT_WAIT])
		&& !(dbg_s && system_control_r[B_HALT_DEBUG]);
	assign tk.active = active;
	assign tk.sel    = ovp_r[2:0];
	assign act_w     = {act_hi_r, act_lo_r};
	assign fast      = system_control_r[B_FAST_CLR];

	tcc_prescale u_pre (.clk(CLK), .arst_n(ARST_N), .tk(tk));
	tcc_edge u_edge (
		.clk(CLK), .arst_n(ARST_N), .active(active), .pin_s(pin_s),
		.edge_cfg({edg_hi_r, edg_lo_r}), .cap(cap));

	for (genvar n = 0; n < 8; n++) begin : g_ch
		logic [1:0] a;
		logic       base;
		assign a = act_w[2*n+1:2*n];
		assign match[n] = tk.tick && ios_r[n] && cnt_r == tc_r[n];
		assign base = !match[n] ? oc_r[n] :
			a == ACT_TOG ? !oc_r[n] :
			a == ACT_CLR ? 1'b0 :
			a == ACT_SET ? 1'b1 : oc_r[n];
		assign oc_nxt[n] = (ch7_hit && c7m_r[n]) ? c7d_r[n] : base;
		assign force_w[n] = (a != ACT_OFF) || (ios_r[n] && c7m_r[n]);
	end
	assign ch7_hit = match[7];
	// wrap only when counting past all ones
	assign wrap = tk.tick && cnt_r == CNT_MAX
		&& !(ch7_hit && ovp_r[B_CLR_ON_CH7]);

	////////////////////////////////////////////////////////////////////////
	// counter, flags, channel values
	logic w8, w16, rd_cnt, wr_cnt, pa_acc;
	logic [7:0] flg_clr;
	assign w8     = wr_do && wstrb_r[0];
	assign w16    = wr_do && wstrb_r[1:0] == 2'h3;
	assign rd_cnt = ar_fire && rix == IX_COUNT;
	assign wr_cnt = wr_do && wix_r == IX_COUNT;
	assign pa_acc = (ar_fire && rix == IX_PA_COUNT)
		|| (wr_do && wix_r == IX_PA_COUNT);

	for (genvar n = 0; n < 8; n++) begin : g_clr
		assign flg_clr[n] =
			(w8 && wix_r == IX_CH_FLAGS && wdata_r[n])
			|| (fast && r_tc && r_ch == n && !ios_r[n])
			|| (fast && w_tc && w_ch == n && ios_r[n]);
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cnt_r <= RST_WORD;
		end else if (w16 && wix_r == IX_COUNT && spec_s) begin
			cnt_r <= wdata_r[15:0];
		end else if (tk.tick) begin
			if (ch7_hit && ovp_r[B_CLR_ON_CH7])
				cnt_r <= RST_WORD;
			else
				cnt_r <= cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			flg_r <= RST_BYTE;
			tof_r <= 1'b0;
		end else begin
			flg_r <= (flg_r & ~flg_clr) | match | (cap & ~ios_r);
			tof_r <= (tof_r && !(w8 && wix_r == IX_OVF_FLAG
				&& wdata_r[B_OVF_FLAG])
				&& !(fast && (rd_cnt || wr_cnt))) || wrap;
		end
	end

	for (genvar n = 0; n < 8; n++) begin : g_tc
		always_ff @(posedge CLK or negedge ARST_N) begin
			if (!ARST_N)
				tc_r[n] <= RST_WORD;
			else if (cap[n] && !ios_r[n])
				tc_r[n] <= cnt_r;
			else if (w16 && w_tc && w_ch == n && ios_r[n])
				tc_r[n] <= wdata_r[15:0];
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ios_r <= RST_BYTE;
			c7m_r <= RST_BYTE;
			c7d_r <= RST_BYTE;
			system_control_r <= RST_BYTE;
			act_hi_r <= RST_BYTE;
			act_lo_r <= RST_BYTE;
			edg_hi_r <= RST_BYTE;
			edg_lo_r <= RST_BYTE;
			ien_r <= RST_BYTE;
			ovp_r <= RST_BYTE;
		end else if (w8) begin
			case (wix_r)
				IX_FUNC_SEL:  ios_r <= wdata_r[7:0];
				IX_C7_MASK:   c7m_r <= wdata_r[7:0];
				IX_C7_DATA:   c7d_r <= wdata_r[7:0];
				IX_SYS_CTRL:  system_control_r <= wdata_r[7:0];
				IX_ACT_HI:    act_hi_r <= wdata_r[7:0];
				IX_ACT_LO:    act_lo_r <= wdata_r[7:0];
				IX_EDGE_HI:   edg_hi_r <= wdata_r[7:0];
				IX_EDGE_LO:   edg_lo_r <= wdata_r[7:0];
				IX_CH_IRQ_EN: ien_r <= wdata_r[7:0];
				IX_OVF_PRE:   ovp_r <= wdata_r[7:0];
				default:      ios_r <= ios_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pins and requests
	logic [7:0] tp_out_r, tp_oe_r, irq_ch_r;
	logic       irq_ovf_r, div64_r, paclr_r;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			oc_r <= RST_BYTE;
			tp_out_r <= RST_BYTE;
			tp_oe_r <= RST_BYTE;
			irq_ch_r <= RST_BYTE;
			irq_ovf_r <= 1'b0;
			div64_r <= 1'b0;
			paclr_r <= 1'b0;
		end else begin
			oc_r <= oc_nxt;
			tp_out_r <= (force_w & oc_nxt) | (~force_w & PORT_DATA);
			tp_oe_r <= force_w | PORT_DIR;
			irq_ch_r <= flg_r & ien_r;
			irq_ovf_r <= tof_r && ovp_r[B_OVF_IRQ_EN];
			div64_r <= tk.div64;
			paclr_r <= fast && pa_acc;
		end
	end

	assign AWREADY = awready_r;
	assign WREADY = wready_r;
	assign BVALID = bvalid_r;
	assign BRESP = bresp_r;
	assign ARREADY = arready_r;
	assign RVALID = rvalid_r;
	assign RDATA = rdata_r;
	assign RRESP = rresp_r;
	assign TP_OUT = tp_out_r;
	assign TP_OE = tp_oe_r;
	assign IRQ_CH = irq_ch_r;
	assign IRQ_OVF = irq_ovf_r;
	assign PA_DIV64 = div64_r;
	assign PA_FLAG_CLR = paclr_r;

	////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	a_ovf_on_wrap: assert property (wrap |=> tof_r)
		else $error("overflow flag not set on wrap");
	a_cnt_wr_normal: assert property (
		wr_cnt && !spec_s && !tk.tick |=> cnt_r == $past(cnt_r))
		else $error("counter changed by normal-mode write");
	a_halt_count: assert property (
		!system_control_r[B_TIMER_ON] && !wr_cnt |=> $stable(cnt_r) && !div64_r)
		else $error("counter ran while timer off");
	a_wait_halt: assert property (
		wait_s && system_control_r[B_HALT_WAIT] |-> !tk.tick)
		else $error("timer ticked in wait");
	a_debug_halt: assert property (
		dbg_s && system_control_r[B_HALT_DEBUG] |-> !tk.tick && !(|cap))
		else $error("timer ran in debug");
	a_fast_ovf_clr: assert property (
		fast && rd_cnt && !wrap |=> !tof_r)
		else $error("counter access kept overflow flag");
	a_ch7_reset: assert property (
		ch7_hit && ovp_r[B_CLR_ON_CH7] && !wr_cnt |=> cnt_r == RST_WORD)
		else $error("counter not cleared on ch7 compare");
	a_pin_force: assert property (
		force_w != 8'h00 |=> (tp_oe_r & $past(force_w)) == $past(force_w))
		else $error("forced pin not driven");
	a_c7_override: assert property (
		ch7_hit |=> ((oc_r ^ $past(c7d_r)) & $past(c7m_r)) == 8'h00)
		else $error("ch7 data not applied");
	a_flag_set: assert property (
		match != 8'h00 |=> (flg_r & $past(match)) == $past(match))
		else $error("compare flag not set");
	for (genvar n = 0; n < 8; n++) begin : g_cap_chk
		a_capture: assert property (
			cap[n] && !ios_r[n] |=> tc_r[n] == $past(cnt_r))
			else $error("capture value wrong");
	end
	a_axi_resp: assert property (wr_do |=> bvalid_r ##0 !awready_r)
		else $error("write response missing");

	c_ch7_reset: cover property (ch7_hit && ovp_r[B_CLR_ON_CH7]);
	c_capture:   cover property (|cap);
	c_wrap:      cover property (wrap);
	c_fast_clr:  cover property (fast && r_tc);
endmodule : tcc_core
`default_nettype wire

/* File: tb/tcc_pin_model.sv */
// pin-level model of the timer port seen from outside the core
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
	input  wire logic       clk,
	input  wire logic [7:0] tp_out,
	input  wire logic [7:0] tp_oe,
	input  wire logic [7:0] ext_lvl,
	input  wire logic [7:0] ext_en,
	output logic      [7:0] pin
);
	logic [7:0] float_r = 8'h00;
	// undriven pins wander so a stale level never reads as valid
	always @(posedge clk) float_r <= ~float_r;
	assign pin = (tp_oe & tp_out) | (~tp_oe & ext_en & ext_lvl)
		| (~tp_oe & ~ext_en & float_r);
endmodule : tcc_pin_model
`default_nettype wire

/* File: tb/tcc_core_tb.sv */
// register-level testbench of the timer capture/compare core
`timescale 1ns/1ns
`default_nettype none
module tcc_core_tb;
	import tcc_pkg::*;
	logic              CLK = 1'b0, ARST_N = 1'b0;
	logic              AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
	logic              ARVALID = 1'b0, RREADY = 1'b0;
	logic [ADDR_W-1:0] AWADDR = '0, ARADDR = '0;
	logic [31:0]       WDATA = '0, RDATA;
	logic              AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0]        BRESP, RRESP, wr_resp, rd_resp;
	logic [7:0]        TP_IN, TP_OUT, TP_OE, IRQ_CH;
	logic              WAIT_MODE = 1'b0, SPECIAL_MODE = 1'b0;
	logic              DEBUG_MODE = 1'b0;
	logic              IRQ_OVF, PA_DIV64, PA_FLAG_CLR;
	logic [7:0]        ext_lvl = 8'h00;
	logic [31:0]       rd_data, a;
	logic [15:0]       dlt;
	int                err_total = 0, check_count = 0, i;
	int                div64_n = 0, paclr_n = 0, q;
	logic [7:0]        rst_ix [5] = '{IX_COUNT, IX_SYS_CTRL, IX_CH_FLAGS,
		IX_OVF_FLAG, IX_OVF_PRE};
	logic [1:0]        act [4] = '{ACT_SET, ACT_TOG, ACT_TOG, ACT_CLR};
	logic [3:0]        exp_pin = 4'b0101;
	logic [7:0]        halt_sys [4] = '{8'hC0, 8'h00, 8'hA0, 8'h80};
	logic [3:0]        halt_exp = 4'b0111;

	always #20 CLK = ~CLK;

	// pulse counters for the two one-cycle outputs
	always @(posedge CLK) begin
		if (PA_DIV64 === 1'b1)
			div64_n <= div64_n + 1;
		if (PA_FLAG_CLR === 1'b1)
			paclr_n <= paclr_n + 1;
	end

	tcc_core dut_u (.CLK(CLK), .ARST_N(ARST_N), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID),
		.WREADY(WREADY), .WDATA(WDATA), .WSTRB(4'hF), .BVALID(BVALID),
		.BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID),
		.RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .TP_IN(TP_IN),
		.PORT_DIR(8'h00), .PORT_DATA(8'h00), .WAIT_MODE(WAIT_MODE),
		.DEBUG_MODE(DEBUG_MODE), .SPECIAL_MODE(SPECIAL_MODE),
		.TP_OUT(TP_OUT),
		.TP_OE(TP_OE), .IRQ_CH(IRQ_CH), .IRQ_OVF(IRQ_OVF),
		.PA_DIV64(PA_DIV64), .PA_FLAG_CLR(PA_FLAG_CLR));

	tcc_pin_model pins_u (.clk(CLK), .tp_out(TP_OUT), .tp_oe(TP_OE),
		.ext_lvl(ext_lvl), .ext_en(8'h04), .pin(TP_IN));

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic to_fail;
		err_total++;
		give_verdict;
	endtask : to_fail

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_data

	task automatic chk_pin(input logic got, input logic exp);
		chk_data({31'h0, got}, {31'h0, exp});
	endtask : chk_pin

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk_data({30'h0, got}, {30'h0, exp});
	endtask : chk_resp

	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask : cyc

	task automatic axi_wr(input logic [7:0] ix, input logic [31:0] d);
		logic aw, w, b;
		int   n;
		aw = 1'b0;
		w = 1'b0;
		b = 1'b0;
		AWVALID <= 1'b1;
		AWADDR <= {ix, 2'b00};
		WVALID <= 1'b1;
		WDATA <= d;
		for (n = 0; n < 50 && !(aw && w); n++) begin
			@(posedge CLK);
			if (!aw && AWREADY) begin
				aw = 1'b1;
				AWVALID <= 1'b0;
			end
			if (!w && WREADY) begin
				w = 1'b1;
				WVALID <= 1'b0;
			end
		end
		if (!(aw && w)) to_fail;
		BREADY <= 1'b1;
		for (n = 0; n < 50 && !b; n++) begin
			@(posedge CLK);
			if (BVALID) begin
				b = 1'b1;
				wr_resp = BRESP;
			end
		end
		BREADY <= 1'b0;
		if (!b) to_fail;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] ix);
		logic ar, r;
		int   n;
		ar = 1'b0;
		r = 1'b0;
		ARVALID <= 1'b1;
		ARADDR <= {ix, 2'b00};
		for (n = 0; n < 50 && !ar; n++) begin
			@(posedge CLK);
			if (ARREADY) begin
				ar = 1'b1;
				ARVALID <= 1'b0;
				RREADY <= 1'b1;
			end
		end
		for (n = 0; n < 50 && ar && !r; n++) begin
			@(posedge CLK);
			if (RVALID) begin
				r = 1'b1;
				rd_data = RDATA;
				rd_resp = RRESP;
			end
		end
		RREADY <= 1'b0;
		if (!r) to_fail;
	endtask : axi_rd

	task automatic rd_chk(input logic [7:0] ix, input logic [31:0] exp);
		axi_rd(ix);
		chk_resp(rd_resp, RESP_OKAY);
		chk_data(rd_data, exp);
	endtask : rd_chk

	////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(10);
		ARST_N <= 1'b1;
		cyc(2);
		for (i = 0; i < 5; i++) rd_chk(rst_ix[i], 32'h0);
		axi_rd(8'h81);
		chk_resp(rd_resp, RESP_SLVERR);
		chk_data(rd_data, 32'h0);
		axi_wr(8'h81, 32'hFF);
		chk_resp(wr_resp, RESP_SLVERR);
		axi_wr(IX_COUNT, 32'h1234);
		chk_resp(wr_resp, RESP_OKAY);
		rd_chk(IX_COUNT, 32'h0);
		SPECIAL_MODE <= 1'b1;
		cyc(4);
		axi_wr(IX_FUNC_SEL, 32'h01);
		for (i = 0; i < 4; i++) begin
			axi_wr(IX_SYS_CTRL, 32'h00);
			axi_wr(IX_COUNT, 32'h0);
			axi_wr(IX_CH_FLAGS, 32'hFF);
			axi_wr(8'h90, 32'h40);
			axi_wr(IX_ACT_LO, {30'h0, act[i]});
			axi_wr(IX_SYS_CTRL, 32'h80);
			cyc(100);
			chk_pin(TP_OE[0], 1'b1);
			chk_pin(TP_OUT[0], exp_pin[i]);
			rd_chk(IX_CH_FLAGS, 32'h01);
		end
		axi_wr(IX_ACT_LO, 32'h0);
		cyc(3);
		chk_pin(TP_OE[0], 1'b0);
		axi_wr(IX_SYS_CTRL, 32'h90);
		axi_wr(8'h90, 32'h40);
		rd_chk(IX_CH_FLAGS, 32'h00);
		// channel 7 drives masked pins and wins over channel 0
		axi_wr(IX_SYS_CTRL, 32'h00);
		axi_wr(IX_COUNT, 32'h0);
		axi_wr(IX_FUNC_SEL, 32'h83);
		axi_wr(IX_C7_MASK, 32'h03);
		axi_wr(IX_C7_DATA, 32'h03);
		axi_wr(8'h9E, 32'h20);
		axi_wr(8'h90, 32'h20);
		axi_wr(IX_ACT_LO, {30'h0, ACT_CLR});
		axi_wr(IX_OVF_PRE, 32'h08);
		axi_wr(IX_SYS_CTRL, 32'h80);
		cyc(100);
		chk_pin(TP_OE[1], 1'b1);
		chk_pin(TP_OUT[1], 1'b1);
		chk_pin(TP_OUT[0], 1'b1);
		axi_rd(IX_COUNT);
		chk_pin(rd_data < 32'h21, 1'b1);
		axi_wr(IX_SYS_CTRL, 32'h00);
		axi_wr(IX_COUNT, 32'h0);
		axi_wr(8'h9E, 32'h0);
		axi_wr(IX_SYS_CTRL, 32'h80);
		cyc(20);
		rd_chk(IX_COUNT, 32'h0);
		// overflow flag and its request
		axi_wr(IX_SYS_CTRL, 32'h00);
		axi_wr(IX_OVF_PRE, 32'h80);
		axi_wr(IX_COUNT, 32'hFFF0);
		axi_wr(IX_SYS_CTRL, 32'h80);
		cyc(40);
		rd_chk(IX_OVF_FLAG, 32'h80);
		chk_pin(IRQ_OVF, 1'b1);
		axi_wr(IX_OVF_FLAG, 32'h00);
		rd_chk(IX_OVF_FLAG, 32'h80);
		axi_wr(IX_OVF_FLAG, 32'h80);
		rd_chk(IX_OVF_FLAG, 32'h00);
		cyc(2);
		chk_pin(IRQ_OVF, 1'b0);
		// halting while the processor waits or is in debug
		WAIT_MODE <= 1'b1;
		DEBUG_MODE <= 1'b1;
		for (i = 0; i < 4; i++) begin
			axi_wr(IX_SYS_CTRL, {24'h0, halt_sys[i]});
			cyc(5);
			axi_rd(IX_COUNT);
			a = rd_data;
			q = div64_n;
			cyc(70);
			axi_rd(IX_COUNT);
			chk_pin(rd_data === a, halt_exp[i]);
			chk_pin(div64_n == q, halt_exp[i]);
		end
		WAIT_MODE <= 1'b0;
		DEBUG_MODE <= 1'b0;
		axi_wr(IX_OVF_PRE, 32'h05);
		cyc(200);
		axi_rd(IX_COUNT);
		a = rd_data;
		cyc(320);
		axi_rd(IX_COUNT);
		dlt = rd_data[15:0] - a[15:0];
		chk_pin(dlt inside {16'hA, 16'hB}, 1'b1);
		// capture on rising edges of pin 2
		axi_wr(IX_OVF_PRE, 32'h00);
		axi_wr(IX_FUNC_SEL, 32'h00);
		axi_wr(IX_C7_MASK, 32'h00);
		axi_wr(IX_EDGE_LO, 32'h10);
		axi_wr(IX_CH_IRQ_EN, 32'h04);
		axi_wr(IX_SYS_CTRL, 32'h90);
		axi_wr(IX_CH_FLAGS, 32'hFF);
		axi_rd(IX_COUNT);
		a = rd_data;
		ext_lvl[2] <= 1'b1;
		cyc(10);
		rd_chk(IX_CH_FLAGS, 32'h04);
		chk_pin(IRQ_CH[2], 1'b1);
		axi_rd(8'h94);
		dlt = rd_data[15:0] - a[15:0];
		chk_pin(dlt inside {[16'h0:16'h20]}, 1'b1);
		rd_chk(IX_CH_FLAGS, 32'h00);
		chk_pin(IRQ_CH[2], 1'b0);
		q = paclr_n;
		rd_chk(IX_PA_COUNT, 32'h0);
		cyc(2);
		chk_data(paclr_n - q, 32'h1);
		ext_lvl[2] <= 1'b0;
		cyc(10);
		rd_chk(IX_CH_FLAGS, 32'h00);
		give_verdict;
	end
endmodule : tcc_core_tb
`default_nettype wire
